// ---- mcp_pkg.sv ----
package mcp_pkg;
    // ------------------------------------------------------------
    // Channel widths and time
    // ------------------------------------------------------------
    localparam int unsigned CHAN_W      = 16;
    localparam int unsigned DISP_W      = 64;
    localparam int unsigned DISP_LO     = 48;
    localparam int unsigned DISP_HI     = 63;
    localparam int unsigned CLK_MHZ     = 100;
    localparam int unsigned MCLR_MIN_US = 3;
    // Least hold rounds up; whole microseconds make it exact
    localparam int unsigned MCLR_CYC    = MCLR_MIN_US * CLK_MHZ;
    localparam int unsigned CNT_W       = 16;

    // ------------------------------------------------------------
    // Command channel bit positions
    // ------------------------------------------------------------
    localparam int unsigned CMD_MEM_CLR  = 0;
    localparam int unsigned CMD_STOP     = 1;
    localparam int unsigned CMD_STEP     = 2;
    localparam int unsigned CMD_RUN      = 3;
    localparam int unsigned CMD_SAVE     = 4;
    localparam int unsigned CMD_LOAD     = 5;
    localparam int unsigned CMD_CPU_CLR  = 6;
    localparam int unsigned CMD_FLT_CLR  = 7;
    localparam int unsigned CMD_SBE_CLR  = 8;
    localparam int unsigned CMD_SYNC     = 9;
    localparam int unsigned CMD_READ     = 11;
    localparam int unsigned CMD_SEL_LO   = 12;
    localparam int unsigned SEL_W        = 4;

    // ------------------------------------------------------------
    // Status channel bit positions
    // ------------------------------------------------------------
    localparam int unsigned ST_DBE       = 0;
    localparam int unsigned ST_CSPAR     = 1;
    localparam int unsigned ST_MMATCH    = 2;
    localparam int unsigned ST_BOUNDS    = 3;
    localparam int unsigned ST_EVENT     = 4;
    localparam int unsigned ST_SBE       = 5;
    localparam int unsigned ST_CPUCLK    = 6;
    localparam int unsigned ST_MONITOR   = 7;
    localparam int unsigned ST_TEMP      = 8;
    localparam int unsigned ST_SECT_PF   = 10;
    localparam int unsigned ST_MF_PF     = 11;
    localparam int unsigned ST_OPT_PF    = 12;
    localparam int unsigned ST_IDLE      = 14;
    localparam int unsigned ST_STOPPED   = 15;
    localparam int unsigned FLT_W        = 5;

    // ------------------------------------------------------------
    // Save / load base addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ASSOC_BASE   = 16'h4000;
    localparam logic [15:0] RFILE_BASE   = 16'h0000;

    // ------------------------------------------------------------
    // Host bus register map
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CMD      = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_DISP     = 8'h08;
    localparam logic [7:0]  REG_HSTAT    = 8'h0C;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        MCP_RUN   = 3'h0,
        MCP_HALT  = 3'h1,
        MCP_STEP  = 3'h2,
        MCP_SAVE  = 3'h3,
        MCP_LOAD  = 3'h4
    } mcp_cpu_t;
endpackage : mcp_pkg

// ---- mcp_if.sv ----
`timescale 1ns/1ps
interface mcp_if;
    logic [15:0] display_upper_channel;
    logic [15:0] status_channel;
    logic [15:0] command_channel;

    modport cpu (
        input  command_channel,
        output display_upper_channel,
        output status_channel
    );
    modport mcu (
        output command_channel,
        input  display_upper_channel,
        input  status_channel
    );
endinterface : mcp_if

// ---- mcp_cpu_port.sv ----
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module mcp_cpu_port
    import mcp_pkg::*;
#(
    parameter int unsigned MCLR_CYCLES = MCLR_CYC
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    // Maintenance channels
    mcp_if.cpu                      mcu,
    // Processor side
    input  wire logic               cpu_clk_phase,
    input  wire logic [FLT_W-1:0]   fault_evt,
    input  wire logic               sbe_evt,
    input  wire logic               event_stop,
    input  wire logic               monitor_mode,
    input  wire logic               temp_alarm,
    input  wire logic               section_pf,
    input  wire logic               mainframe_pf,
    input  wire logic               option_pf,
    input  wire logic               instr_done,
    input  wire logic               xfer_done,
    input  wire logic [DISP_W-1:0]  reg_view,
    input  wire logic [DISP_W-1:0]  instr_addr,
    output logic                    mem_clear,
    output logic                    cpu_clear,
    output logic                    issue_en,
    output logic                    xfer_save,
    output logic                    xfer_load,
    output logic                    xfer_virtual,
    output logic [15:0]             assoc_addr,
    output logic [15:0]             rfile_addr,
    output logic [SEL_W-1:0]        view_sel,
    output logic [DISP_W-1:0]       ia_display
);
    // ------------------------------------------------------------
    // Command edges
    // ------------------------------------------------------------
    logic [CHAN_W-1:0] cmd_q_r;
    wire  [CHAN_W-1:0] cmd = mcu.command_channel;
    wire  [CHAN_W-1:0] rise = cmd & ~cmd_q_r;

    mcp_cpu_t          st_r, st_nxt;
    logic [FLT_W-1:0]  flt_r;
    logic              sbe_r, evstop_r;
    logic [DISP_W-1:0] disp_r;
    logic [CNT_W-1:0]  mem_cnt_r, cpu_cnt_r;
    logic [CHAN_W-1:0] stat_r;

    wire faulted = |flt_r;
    wire halted  = (st_r == MCP_HALT);

    // Clear counts measure the held level; short pulses never fire
    function automatic logic [CNT_W-1:0] hold_cnt(input logic lvl,
                                                  input logic [CNT_W-1:0] c);
        hold_cnt = !lvl ? '0 : (c == CNT_W'(MCLR_CYCLES)) ? c : c + 1'b1;
    endfunction : hold_cnt

    wire mem_clr_act = (mem_cnt_r == CNT_W'(MCLR_CYCLES));
    wire cpu_clr_act = (cpu_cnt_r == CNT_W'(MCLR_CYCLES));

    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------
    // Step and run are dropped unless the fault register is clean; stop acts only in the run state
    wire stop_req = rise[CMD_STOP];
    wire step_req = rise[CMD_STEP] && halted && !faulted;
    wire run_req  = rise[CMD_RUN] && halted && !faulted;
    wire save_req = rise[CMD_SAVE] && halted;
    wire load_req = rise[CMD_LOAD] && halted;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            MCP_RUN: begin
                if (stop_req || faulted || evstop_r)
                    st_nxt = MCP_HALT;
            end
            MCP_HALT: begin
                if (step_req)
                    st_nxt = MCP_STEP;
                else if (run_req)
                    st_nxt = MCP_RUN;
                else if (save_req)
                    st_nxt = MCP_SAVE;
                else if (load_req)
                    st_nxt = MCP_LOAD;
            end
            MCP_STEP: begin
                if (instr_done)
                    st_nxt = monitor_mode ? MCP_HALT : MCP_SAVE;
            end
            MCP_SAVE, MCP_LOAD: begin
                if (xfer_done)
                    st_nxt = MCP_HALT;
            end
            default: st_nxt = MCP_HALT;
        endcase
        if (cpu_clr_act)
            st_nxt = MCP_HALT;
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    // Stop and idle follow the next state so they line up with issue_en
    wire               show_stop = (st_nxt == MCP_HALT);
    wire               show_idle = show_stop && !faulted;
    logic [CHAN_W-1:0] stat_nxt;

    always_comb begin
        stat_nxt              = '0;
        stat_nxt[ST_DBE]      = flt_r[ST_DBE] | flt_r[FLT_W-1];
        stat_nxt[ST_CSPAR]    = flt_r[ST_CSPAR];
        stat_nxt[ST_MMATCH]   = flt_r[ST_MMATCH];
        stat_nxt[ST_BOUNDS]   = flt_r[ST_BOUNDS];
        stat_nxt[ST_EVENT]    = evstop_r;
        stat_nxt[ST_SBE]      = sbe_r;
        stat_nxt[ST_CPUCLK]   = cpu_clk_phase;
        stat_nxt[ST_MONITOR]  = monitor_mode;
        stat_nxt[ST_TEMP]     = temp_alarm;
        stat_nxt[ST_SECT_PF]  = section_pf;
        stat_nxt[ST_MF_PF]    = mainframe_pf;
        stat_nxt[ST_OPT_PF]   = option_pf;
        stat_nxt[ST_IDLE]     = show_idle;
        stat_nxt[ST_STOPPED]  = show_stop;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q_r   <= '0;
            st_r      <= MCP_HALT;
            flt_r     <= '0;
            sbe_r     <= 1'b0;
            evstop_r  <= 1'b0;
            mem_cnt_r <= '0;
            cpu_cnt_r <= '0;
        end else begin
            cmd_q_r   <= cmd;
            st_r      <= st_nxt;
            // New fault wins over a clear in the same cycle
            flt_r     <= (rise[CMD_FLT_CLR] || cpu_clr_act ? '0 : flt_r)
                         | fault_evt;
            sbe_r     <= (rise[CMD_SBE_CLR] ? 1'b0 : sbe_r) | sbe_evt;
            evstop_r  <= (rise[CMD_RUN] || rise[CMD_STEP] ? 1'b0 : evstop_r)
                         | event_stop;
            mem_cnt_r <= hold_cnt(cmd[CMD_MEM_CLR], mem_cnt_r);
            cpu_cnt_r <= hold_cnt(cmd[CMD_CPU_CLR], cpu_cnt_r);
        end
    end

    // ------------------------------------------------------------
    // Outputs and display
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_clear    <= 1'b0;
            cpu_clear    <= 1'b0;
            issue_en     <= 1'b0;
            xfer_save    <= 1'b0;
            xfer_load    <= 1'b0;
            xfer_virtual <= 1'b0;
            assoc_addr   <= ASSOC_BASE;
            rfile_addr   <= RFILE_BASE;
            view_sel     <= '0;
            disp_r       <= '0;
            ia_display   <= '0;
            stat_r       <= '0;
        end else begin
            mem_clear    <= mem_clr_act;
            cpu_clear    <= cpu_clr_act;
            issue_en     <= (st_nxt == MCP_RUN) || (st_nxt == MCP_STEP);
            xfer_save    <= (st_nxt == MCP_SAVE);
            xfer_load    <= (st_nxt == MCP_LOAD);
            xfer_virtual <= !monitor_mode;
            assoc_addr   <= ASSOC_BASE;
            rfile_addr   <= RFILE_BASE;
            view_sel     <= cmd[CMD_SEL_LO +: SEL_W];
            if (rise[CMD_READ]) begin
                disp_r     <= reg_view;
                ia_display <= instr_addr;
            end
            stat_r       <= stat_nxt;
        end
    end

    assign mcu.display_upper_channel = disp_r[DISP_HI:DISP_LO];
    assign mcu.status_channel        = stat_r;
endmodule : mcp_cpu_port

// ---- mcp_mcu_ctrl.sv ----
`timescale 1ns/1ps
module mcp_mcu_ctrl
    import mcp_pkg::*;
(
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [7:0]   haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic         hready,
    input  wire logic [31:0]  hwdata,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // Maintenance channels
    mcp_if.mcu                mcu
);
    // ------------------------------------------------------------
    // Bus capture
    // ------------------------------------------------------------
    logic              wr_r;
    logic [7:0]        addr_r;
    logic [CHAN_W-1:0] cmd_r;
    logic [CHAN_W-1:0] disp_r, stat_r;

    wire take = hsel && hready && (htrans == HTRANS_NONSEQ);
    // Software owns the ordering of read then sync, faults and halts
    // Decoded from the address phase so the word stands through the data phase
    wire [31:0] rd_val = (haddr == REG_CMD)    ? {16'h0000, cmd_r}  :
                         (haddr == REG_STATUS) ? {16'h0000, stat_r} :
                         (haddr == REG_DISP)   ? {16'h0000, disp_r} : 32'h0000_0000;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r      <= 1'b0;
            addr_r    <= '0;
            cmd_r     <= '0;
            disp_r    <= '0;
            stat_r    <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_r   <= take && hwrite;
            addr_r <= take ? haddr : addr_r;
            disp_r <= mcu.display_upper_channel;
            stat_r <= mcu.status_channel;
            if (wr_r && addr_r == REG_CMD)
                cmd_r <= hwdata[CHAN_W-1:0];
            hrdata <= (take && !hwrite) ? rd_val : hrdata;
        end
    end

    assign mcu.command_channel = cmd_r;
    wire unused_ok = |hsize;
endmodule : mcp_mcu_ctrl

// ---- mcp_chk.sv ----
`timescale 1ns/1ps
module mcp_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Channels
    input wire logic [15:0] display_upper_channel,
    input wire logic [15:0] status_channel,
    input wire logic [15:0] command_channel
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire [15:0] st = status_channel;
    wire [15:0] cm = command_channel;

    a_idle_stopped: assert property (st[14] |-> st[15])
        else $error("idle shown while running");
    a_idle_clean: assert property (st[14] |-> st[3:0] == 4'h0)
        else $error("idle shown with a fault");
    a_run_starts: assert property ($rose(cm[3]) && st[14] |-> ##[1:4] !st[15])
        else $error("run did not start");
    a_run_refused: assert property ($rose(cm[3]) && st[3:0] != 4'h0 |-> st[15] [*4])
        else $error("run accepted while faulted");
    a_stop_halts: assert property ($rose(cm[1]) |-> ##[1:20] st[15])
        else $error("stop did not halt");
    a_fault_clear: assert property ($rose(cm[7]) |-> ##[1:4] st[3:0] == 4'h0)
        else $error("faults not cleared");
    a_sbe_clear: assert property ($rose(cm[8]) |-> ##[1:4] !st[5])
        else $error("single error flag not cleared");
    // Display may only move just after a read request
    a_disp_latched: assert property ($changed(display_upper_channel) |->
        $past(cm[11]) || $past(cm[11], 2) || $past(cm[11], 3))
        else $error("display changed without read");

    c_run: cover property ($rose(cm[3]) ##[1:4] !st[15]);
    c_stop: cover property ($rose(cm[1]) ##[1:20] st[15]);
    c_disp: cover property ($changed(display_upper_channel));
endmodule : mcp_chk

// ---- maintenance_channel_port_tb_top.sv ----
`timescale 1ns/1ps
module maintenance_channel_port_tb_top;
    import mcp_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, rd;
    wire [31:0] hrdata;
    wire hreadyout, hresp, mem_clear, cpu_clear, issue_en;
    wire xfer_save, xfer_load, xfer_virtual;
    wire [15:0] assoc_addr, rfile_addr;
    wire [3:0] view_sel;
    wire [63:0] ia_display;
    logic cpu_clk_phase = 1'b0, sbe_evt = 1'b0, event_stop = 1'b0, monitor_mode = 1'b0;
    logic temp_alarm = 1'b0, section_pf = 1'b0, mainframe_pf = 1'b0, option_pf = 1'b0;
    logic instr_done = 1'b0, xfer_done = 1'b0;
    logic [4:0] fault_evt = 5'h00;
    logic [63:0] reg_view = 64'h0, instr_addr = 64'h0;
    logic [15:0] exp_q[$];
    logic [15:0] obs_d = 16'h0;
    logic obs_v = 1'b0;
    logic [3:0] sel;
    int fails = 0, num_checks = 0;

    always #5 ref_clk = ~ref_clk;

    mcp_if mif ();
    mcp_cpu_port #(.MCLR_CYCLES(4)) mcp_cpu_port_inst (.ref_clk, .rst_n, .mcu(mif.cpu),
        .cpu_clk_phase, .fault_evt, .sbe_evt, .event_stop, .monitor_mode, .temp_alarm,
        .section_pf, .mainframe_pf, .option_pf, .instr_done, .xfer_done, .reg_view,
        .instr_addr, .mem_clear, .cpu_clear, .issue_en, .xfer_save, .xfer_load,
        .xfer_virtual, .assoc_addr, .rfile_addr, .view_sel, .ia_display);
    mcp_mcu_ctrl mcp_mcu_ctrl_inst (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .mcu(mif.mcu));
    mcp_chk mcp_chk_inst (.ref_clk, .rst_n,
        .display_upper_channel(mif.display_upper_channel),
        .status_channel(mif.status_channel), .command_channel(mif.command_channel));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Result and its note meet in the watcher one edge later
    task automatic note(input logic [15:0] e, input logic [15:0] g);
        exp_q.push_back(e);
        obs_d <= g;
        obs_v <= 1'b1;
        @(posedge ref_clk);
        obs_v <= 1'b0;
        @(posedge ref_clk);
    endtask : note

    always @(posedge ref_clk) begin
        if (obs_v && exp_q.size() > 0) check(obs_d, exp_q.pop_front());
    end

    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            report_and_stop;
        end
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask : bus

    task automatic cmd(input logic [15:0] v);
        bus(1'b1, REG_CMD, {16'h0, v});
        repeat (4) @(posedge ref_clk);
    endtask : cmd

    function automatic logic [15:0] stx(input logic s, input logic i, input logic [5:0] f);
        return {s, i, 1'b0, option_pf, mainframe_pf, section_pf, 1'b0,
                temp_alarm, monitor_mode, cpu_clk_phase, f};
    endfunction : stx

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        report_and_stop;
    end

    initial begin
        rd = $urandom(63);
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        note(16'h4000, assoc_addr);
        {monitor_mode, temp_alarm, section_pf, mainframe_pf, option_pf} <= 5'($urandom);
        cpu_clk_phase <= 1'b1;
        repeat (3) @(posedge ref_clk);
        bus(1'b0, REG_STATUS, 32'h0);
        note(stx(1'b1, 1'b1, 6'h00), rd[15:0]);
        fault_evt <= 5'h12;
        cpu_clk_phase <= 1'b0;
        @(posedge ref_clk);
        fault_evt <= 5'h00;
        repeat (3) @(posedge ref_clk);
        bus(1'b0, REG_STATUS, 32'h0);
        note(stx(1'b1, 1'b0, 6'h03), rd[15:0]);
        cmd(16'h0008);
        note(16'h0000, {15'h0, issue_en});
        cmd(16'h0000);
        cmd(16'h0080);
        cmd(16'h0000);
        bus(1'b0, REG_STATUS, 32'h0);
        note(stx(1'b1, 1'b1, 6'h00), rd[15:0]);
        sbe_evt <= 1'b1;
        event_stop <= 1'b1;
        @(posedge ref_clk);
        sbe_evt <= 1'b0;
        event_stop <= 1'b0;
        repeat (3) @(posedge ref_clk);
        bus(1'b0, REG_STATUS, 32'h0);
        note(16'h0030, rd[15:0] & 16'h0030);
        cmd(16'h0100);
        bus(1'b0, REG_STATUS, 32'h0);
        note(16'h0000, rd[15:0] & 16'h0020);
        cmd(16'h0008);
        note(16'h0001, {15'h0, issue_en});
        cmd(16'h0002);
        instr_done <= 1'b1;
        @(posedge ref_clk);
        instr_done <= 1'b0;
        repeat (4) @(posedge ref_clk);
        note(16'h0000, {15'h0, issue_en});
        cmd(16'h0000);
        cmd(16'h0004);
        note(16'h0001, {15'h0, issue_en});
        instr_done <= 1'b1;
        @(posedge ref_clk);
        instr_done <= 1'b0;
        repeat (3) @(posedge ref_clk);
        note({15'h0, !monitor_mode}, {15'h0, xfer_save});
        xfer_done <= 1'b1;
        @(posedge ref_clk);
        xfer_done <= 1'b0;
        repeat (6) @(posedge ref_clk);
        // Step bit still held high: no second step may follow
        note(16'h0000, {15'h0, issue_en});
        for (int i = 4; i < 6; i++) begin
            cmd(16'(1 << i));
            note(16'(i - 3), {14'h0, xfer_load, xfer_save});
            note({15'h0, !monitor_mode}, {15'h0, xfer_virtual});
            note(16'h0000, rfile_addr);
            xfer_done <= 1'b1;
            @(posedge ref_clk);
            xfer_done <= 1'b0;
            cmd(16'h0000);
        end
        reg_view <= {$urandom, $urandom};
        instr_addr <= {$urandom, $urandom};
        sel = 4'($urandom);
        cmd({sel, 12'h800});
        cmd({sel, 12'hA00});
        bus(1'b0, REG_DISP, 32'h0);
        note(reg_view[63:48], rd[15:0]);
        note({12'h0, sel}, {12'h0, view_sel});
        note(instr_addr[15:0], ia_display[15:0]);
        bus(1'b0, REG_HSTAT, 32'h0);
        note(16'h0000, rd[15:0]);
        note(16'h0000, {15'h0, hresp});
        for (int i = 0; i < 2; i++) begin
            cmd(i ? 16'h0040 : 16'h0001);
            repeat (4) @(posedge ref_clk);
            note(i ? 16'h0002 : 16'h0001, {14'h0, cpu_clear, mem_clear});
            cmd(16'h0000);
            note(16'h0000, {14'h0, cpu_clear, mem_clear});
        end
        repeat (3) @(posedge ref_clk);
        report_and_stop;
    end
endmodule : maintenance_channel_port_tb_top
